/* mcrc_defines.svh */
// Offsets, field positions, reset values and sizes for the memory checker CRC engine.
// Assumes inclusion by bare name from any file that needs them.
`ifndef MCRC_DEFINES_SVH
`define MCRC_DEFINES_SVH
`define MCRC_OFF_CTRL     4'h0
`define MCRC_OFF_POLY     4'h1
`define MCRC_OFF_SEED     4'h2
`define MCRC_OFF_DATA     4'h3
`define MCRC_OFF_BLEN     4'h4
`define MCRC_OFF_EXPECT   4'h5
`define MCRC_OFF_SIG      4'h6
`define MCRC_OFF_STATUS   4'h7
`define MCRC_OFF_RESULT   4'h8
`define MCRC_CTRL_ENABLE  0
`define MCRC_CTRL_CMP_EN  1
`define MCRC_CTRL_IRQ_EN  2
`define MCRC_CTRL_ADVANCE 3
`define MCRC_ST_DONE      0
`define MCRC_ST_ERROR     1
`define MCRC_ST_BUSY      2
`define MCRC_POLY_RST     32'h04C11DB7
`define MCRC_SEED_RST     32'hFFFFFFFF
`define MCRC_BLEN_RST     16'h0001
`define MCRC_WORD_ZERO    32'h00000000
`endif

/* mcrc_pkg.sv */
// Types shared by the memory checker CRC engine files.
// Assumes mcrc_defines.svh is compiled alongside.
package mcrc_pkg;
   typedef enum logic [2:0] {
      MCRC_IDLE = 3'b001,
      MCRC_RUN  = 3'b010,
      MCRC_DONE = 3'b100
   } mcrc_state_t;
endpackage

/* mcrc_lfsr.sv */
// Parallel 16-bit step of the 32-bit signature register with programmable feedback.
// Assumes a single clock and that load and step are never asked for together
// with conflicting intent; load wins.
`timescale 1ns/1ps
`include "mcrc_defines.svh"
module mcrc_lfsr #(
   parameter int SIG_W = 32,
   parameter int DIN_W = 16
) (
   input  wire logic             clk,     // System clock.
   input  wire logic             rst,     // Synchronous reset, high.
   input  wire logic             load,    // Load seed pulse.
   input  wire logic [SIG_W-1:0] seed,    // Seed value.
   input  wire logic             step,    // Compress one word pulse.
   input  wire logic [DIN_W-1:0] din,     // Data word.
   input  wire logic [SIG_W-1:0] poly,    // Feedback polynomial.
   output logic      [SIG_W-1:0] sig_q    // Registered signature.
);
   logic [SIG_W-1:0] sig_r;
   logic [SIG_W-1:0] sig_nxt;

   // Folds a whole word in one cycle by unrolling the serial divider MSB first.
   function automatic logic [SIG_W-1:0] fold(input logic [SIG_W-1:0] s,
                                            input logic [DIN_W-1:0] d,
                                            input logic [SIG_W-1:0] p);
      logic [SIG_W-1:0] t;
      logic             fb;
      t  = s;
      fb = 1'b0;
      for (int i = DIN_W - 1; i >= 0; i--) begin
         fb = t[SIG_W-1] ^ d[i];
         t  = {t[SIG_W-2:0], 1'b0} ^ (fb ? p : `MCRC_WORD_ZERO);
      end
      return t;
   endfunction

   // Next signature: seed load first, then one compression step.
   assign sig_nxt = load ? seed : (step ? fold(sig_r, din, poly) : sig_r);
   assign sig_q   = sig_r;

   // The signature register itself.
   always_ff @(posedge clk) begin
      if (rst) begin
         sig_r <= `MCRC_SEED_RST;
      end else begin
         sig_r <= sig_nxt;
      end
   end
endmodule

/* mcrc_engine.sv */
// Memory checker CRC engine: Avalon-MM register slave, block counter, compare.
// Contract
// - The running signature lives in a 32-bit shift register updated by polynomial division.
// - Each 16-bit data word is folded into the signature in one step.
// - Software programs the feedback polynomial.
// - A local counter of programmable length ends a block and yields a result.
// - The finished block checksum is compared in hardware with an expected value.
// - A mismatch can raise an interrupt request.
// - The shift register can be read and advanced to act as a pseudo-random source.
// Assumes one clock, synchronous reset, and a bus master that holds requests until
// waitrequest is seen low.
`timescale 1ns/1ps
`include "mcrc_defines.svh"
module mcrc_engine #(
   parameter int BLEN_W = 16
) (
   input  wire logic        clk,                // System clock, 20 MHz.
   input  wire logic        rst,                // Synchronous reset, high.
   input  wire logic [3:0]  avs_address,        // Word index.
   input  wire logic        avs_read,           // Read request.
   input  wire logic        avs_write,          // Write request.
   input  wire logic [31:0] avs_writedata,      // Write data.
   input  wire logic [3:0]  avs_byteenable,     // Byte enables.
   output logic      [31:0] avs_readdata,       // Registered read data.
   output logic             avs_waitrequest,    // Registered wait request.
   output logic             mismatch_irq        // Registered error request, high.
);
   ////////////////////////////////////////////////////////////////////////////
   mcrc_pkg::mcrc_state_t state_r;
   mcrc_pkg::mcrc_state_t state_nxt;
   logic [31:0]       poly_r;
   logic [31:0]       seed_r;
   logic [31:0]       expect_r;
   logic [31:0]       result_r;
   logic [BLEN_W-1:0] blen_r;
   logic [BLEN_W-1:0] cnt_r;
   logic [BLEN_W-1:0] cnt_nxt;
   logic [15:0]       din_r;
   logic [3:0]        ctrl_r;
   logic              done_r;
   logic              err_r;
   logic              ack_r;
   logic              irq_r;
   logic [31:0]       rdata_r;
   logic              wait_r;
   logic [31:0]       sig;

   // A request is taken once; waitrequest drops for the cycle after it is seen.
   wire        req     = (avs_read | avs_write) & ~ack_r;
   wire        wr      = avs_write & ~ack_r;
   wire        rd      = avs_read & ~ack_r;
   wire        wr_ctrl = wr & (avs_address == `MCRC_OFF_CTRL);
   wire        wr_poly = wr & (avs_address == `MCRC_OFF_POLY);
   wire        wr_seed = wr & (avs_address == `MCRC_OFF_SEED);
   wire        wr_data = wr & (avs_address == `MCRC_OFF_DATA);
   wire        wr_blen = wr & (avs_address == `MCRC_OFF_BLEN);
   wire        wr_exp  = wr & (avs_address == `MCRC_OFF_EXPECT);
   wire        wr_stat = wr & (avs_address == `MCRC_OFF_STATUS);
   wire        enable  = ctrl_r[`MCRC_CTRL_ENABLE];
   wire [31:0] wmask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // Merges write data into a register under the byte enables.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [31:0] m);
      return (old & ~m) | (wd & m);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // A data write compresses a word; an advance write steps with zero data,
   // which is how the register is used as a pseudo-random source.
   wire        adv     = wr_ctrl & avs_writedata[`MCRC_CTRL_ADVANCE] & avs_byteenable[0];
   wire        step    = (wr_data & enable) | adv;
   wire [15:0] step_d  = wr_data ? avs_writedata[15:0] : 16'h0000;
   // Word count including this one; a block length of 0 or 1 ends every word.
   wire [BLEN_W-1:0] cnt_inc = cnt_r + BLEN_W'(1);
   wire        blk_end = step & wr_data & (cnt_inc >= blen_r);
   wire [31:0] fin_sig;
   wire        cmp_bad = ctrl_r[`MCRC_CTRL_CMP_EN] & (fin_sig != expect_r);

   mcrc_lfsr #(
      .SIG_W (32),
      .DIN_W (16)
   ) u_lfsr (
      .clk   (clk),
      .rst   (rst),
      .load  (wr_seed),
      .seed  (merge(seed_r, avs_writedata, wmask)),
      .step  (step),
      .din   (step_d),
      .poly  (poly_r),
      .sig_q (sig)
   );

   // The finished signature is the same fold the shift register takes this cycle.
   // A second copy of the divider costs area, but lets the result and the compare
   // use the block's last word without waiting a cycle for the register.
   assign fin_sig = fold_peek(sig, step_d, poly_r);

   // Duplicated fold so the compare sees the block's last word without a cycle of delay.
   function automatic logic [31:0] fold_peek(input logic [31:0] s, input logic [15:0] d,
                                             input logic [31:0] p);
      logic [31:0] t;
      logic        fb;
      t  = s;
      fb = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         fb = t[31] ^ d[i];
         t  = {t[30:0], 1'b0} ^ (fb ? p : `MCRC_WORD_ZERO);
      end
      return t;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Block counter: a seed load restarts it, the last word wraps it.
   // Advance steps are not counted, so a pseudo-random run never ends a block.
   always_comb begin
      cnt_nxt = cnt_r;
      if (wr_seed) begin
         cnt_nxt = '0;
      end else if (blk_end) begin
         cnt_nxt = '0;
      end else if (step & wr_data) begin
         cnt_nxt = cnt_inc;
      end
   end

   // Sequencer: idle until enabled, running while words arrive, done after a block.
   always_comb begin
      case (state_r)
         mcrc_pkg::MCRC_IDLE: state_nxt = enable ? mcrc_pkg::MCRC_RUN : mcrc_pkg::MCRC_IDLE;
         mcrc_pkg::MCRC_RUN:  state_nxt = !enable ? mcrc_pkg::MCRC_IDLE :
                                          (blk_end ? mcrc_pkg::MCRC_DONE : mcrc_pkg::MCRC_RUN);
         mcrc_pkg::MCRC_DONE: state_nxt = !enable ? mcrc_pkg::MCRC_IDLE :
                                          ((wr_seed | wr_data) ? mcrc_pkg::MCRC_RUN :
                                           mcrc_pkg::MCRC_DONE);
         default:             state_nxt = mcrc_pkg::MCRC_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped indices read as zero.
   wire [31:0] rmux =
      (avs_address == `MCRC_OFF_CTRL)   ? {28'h0000000, 1'b0, ctrl_r[2:0]} :
      (avs_address == `MCRC_OFF_POLY)   ? poly_r :
      (avs_address == `MCRC_OFF_SEED)   ? seed_r :
      (avs_address == `MCRC_OFF_DATA)   ? {16'h0000, din_r} :
      (avs_address == `MCRC_OFF_BLEN)   ? {{(32-BLEN_W){1'b0}}, blen_r} :
      (avs_address == `MCRC_OFF_EXPECT) ? expect_r :
      (avs_address == `MCRC_OFF_SIG)    ? sig :
      (avs_address == `MCRC_OFF_STATUS) ? {29'h00000000, ~state_r[0], err_r, done_r} :
      (avs_address == `MCRC_OFF_RESULT) ? result_r : `MCRC_WORD_ZERO;

   // Sticky flags: a block end in the same cycle as a clear wins over the clear.
   wire done_nxt = blk_end | (done_r & ~(wr_stat & avs_writedata[`MCRC_ST_DONE]));
   wire err_nxt  = (blk_end & cmp_bad) |
                   (err_r & ~(wr_stat & avs_writedata[`MCRC_ST_ERROR]));

   // Byte-lane merges of the control and block length registers; the advance bit is
   // never stored, so it always reads back as zero.
   wire [31:0] ctrl_m = merge({28'h0000000, ctrl_r}, avs_writedata, wmask);
   wire [31:0] blen_m = merge({{(32-BLEN_W){1'b0}}, blen_r}, avs_writedata, wmask);

   // Configuration registers.
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r   <= 4'h0;
         poly_r   <= `MCRC_POLY_RST;
         seed_r   <= `MCRC_SEED_RST;
         expect_r <= `MCRC_WORD_ZERO;
         blen_r   <= BLEN_W'(`MCRC_BLEN_RST);
      end else begin
         if (wr_ctrl) ctrl_r <= {1'b0, ctrl_m[2:0]};
         if (wr_poly) poly_r <= merge(poly_r, avs_writedata, wmask);
         if (wr_seed) seed_r <= merge(seed_r, avs_writedata, wmask);
         if (wr_exp)  expect_r <= merge(expect_r, avs_writedata, wmask);
         if (wr_blen) blen_r <= blen_m[BLEN_W-1:0];
      end
   end

   // Engine state, result capture and flags.
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r  <= mcrc_pkg::MCRC_IDLE;
         cnt_r    <= '0;
         din_r    <= 16'h0000;
         result_r <= `MCRC_WORD_ZERO;
         done_r   <= 1'b0;
         err_r    <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         done_r  <= done_nxt;
         err_r   <= err_nxt;
         if (wr_data) din_r <= avs_writedata[15:0];
         if (blk_end) result_r <= fin_sig;
      end
   end

   // Bus answer and interrupt, all from flip-flops.
   // Waitrequest has its own flip-flop, the inverse of ack_r, so that the pin is
   // not an inverter behind a register.
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_r   <= 1'b0;
         wait_r  <= 1'b1;
         rdata_r <= `MCRC_WORD_ZERO;
         irq_r   <= 1'b0;
      end else begin
         ack_r  <= req;
         wait_r <= ~req;
         if (rd) rdata_r <= rmux;
         irq_r <= err_nxt & ctrl_r[`MCRC_CTRL_IRQ_EN];
      end
   end

   assign avs_waitrequest = wait_r;
   assign avs_readdata    = rdata_r;
   assign mismatch_irq    = irq_r;
endmodule

/* mcrc_engine_properties.sv */
// Checker for the CRC engine register port and error request.
// Assumes it is bound to mcrc_engine and sees only that module's ports.
`timescale 1ns/1ps
module mcrc_checker #(
   parameter int BLEN_W = 16
) (
   input wire logic        clk,             // Clock.
   input wire logic        rst,             // Reset.
   input wire logic [3:0]  avs_address,     // Index.
   input wire logic        avs_read,        // Read.
   input wire logic        avs_write,       // Write.
   input wire logic [31:0] avs_writedata,   // Write data.
   input wire logic [3:0]  avs_byteenable,  // Lanes.
   input wire logic [31:0] avs_readdata,    // Read data.
   input wire logic        avs_waitrequest, // Wait.
   input wire logic        mismatch_irq     // Error request.
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic        tk_wr;
   logic        irq_en_r;
   logic        fresh_r;
   logic [31:0] seed_r;
   ////////////////////////////////////////////////////////////////////////////////
   // A write is taken at the edge where the slave has not answered yet.
   assign tk_wr = avs_write && avs_waitrequest;
   // Shadows of the interrupt enable and last seed; any later write spoils the seed copy.
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_en_r <= 1'h0;
         fresh_r  <= 1'h0;
      end else if (tk_wr) begin
         fresh_r <= avs_address == 4'h2 && avs_byteenable == 4'hF;
         seed_r  <= avs_writedata;
         if (avs_address == 4'h0 && avs_byteenable[0]) begin
            irq_en_r <= avs_writedata[2];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Access steps, named so the properties read as a handshake.
   sequence s_taken;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   sequence s_rd_at(logic [3:0] a);
      avs_read && avs_waitrequest && avs_address == a;
   endsequence
   property p_answer;
      s_taken |=> s_answer;
   endproperty
   property p_idle;
      !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
   endproperty
   property p_hold;
      !(avs_read && avs_waitrequest) |=> $stable(avs_readdata);
   endproperty
   property p_unmap;
      avs_read && avs_waitrequest && avs_address > 4'h8 |=> avs_readdata == 32'h00000000;
   endproperty
   property p_adv0;
      s_rd_at(4'h0) |=> !avs_readdata[3];
   endproperty
   property p_seed;
      s_rd_at(4'h6) ##0 fresh_r |=> avs_readdata == seed_r;
   endproperty
   property p_gate;
      !irq_en_r |=> !mismatch_irq;
   endproperty
   property p_clr;
      tk_wr && avs_address == 4'h7 && avs_byteenable[0] && avs_writedata[1] |-> ##2 !mismatch_irq;
   endproperty
   a_answer: assert property (p_answer) else $error("No one-cycle answer.");
   a_idle: assert property (p_idle) else $error("Answer without request.");
   a_hold: assert property (p_hold) else $error("Read data moved.");
   a_unmap: assert property (p_unmap) else $error("Unmapped read not zero.");
   a_adv0: assert property (p_adv0) else $error("Advance bit reads one.");
   a_seed: assert property (p_seed) else $error("Signature not seed.");
   a_gate: assert property (p_gate) else $error("Masked error request.");
   a_clr: assert property (p_clr) else $error("Request after clear.");
endmodule
bind mcrc_engine mcrc_checker #(.BLEN_W(BLEN_W)) chk_u (
   .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .mismatch_irq(mismatch_irq));

/* testbench.sv */
// Self-checking bench for the CRC engine through its register port.
// Assumes the engine and its checker are compiled before this file.
`timescale 1ns/1ps
`include "mcrc_defines.svh"
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin miscompares++; \
   $display("BAD t=%0t got %h exp %h", $time, g, x); end end
module testbench;
   logic        clk, rst, avs_read, avs_write, mismatch_irq, avs_waitrequest;
   logic [3:0]  avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, v, s, p, e;
   int          miscompares;
   int          compares;
   mcrc_engine #(.BLEN_W(16)) dut_u (.clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .mismatch_irq(mismatch_irq));
   ////////////////////////////////////////////////////////////////////////////////
   // Free-running 20 MHz clock.
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   // Reference step: sixteen serial shifts, most significant data bit first.
   function automatic logic [31:0] crc(input logic [31:0] r, input logic [15:0] d,
                                       input logic [31:0] q);
      for (int i = 15; i >= 0; i--) r = {r[30:0], 1'h0} ^ ((r[31] ^ d[i]) ? q : 32'h0);
      return r;
   endfunction
   // One access, held until waitrequest is sampled low; read data taken there.
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_read      <= !w;
      avs_write     <= w;
      avs_address   <= a;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'h0);
      v = avs_readdata;
      avs_read  <= 1'h0;
      avs_write <= 1'h0;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [31:0] x);
      acc(1'h0, a, 32'h0);
      `CHK(v, x)
   endtask
   // Feeds n consecutive words and keeps the reference signature in step.
   task automatic words(input int n, input logic [15:0] b);
      for (int k = 0; k < n; k++) begin
         acc(1'h1, 4'h3, {16'h0000, b + 16'(k)});
         s = crc(s, b + 16'(k), p);
      end
   endtask
   task automatic close_out;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Cuts a hang short; the whole run needs well under 1000 cycles.
   initial begin
      #(50 * 5000);
      miscompares++;
      close_out;
   end
   // Main sequence of register accesses.
   initial begin
      rst = 1'h1;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      miscompares = 0;
      compares = 0;
      s = `MCRC_SEED_RST;
      p = `MCRC_POLY_RST;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      rdchk(4'h1, `MCRC_POLY_RST);
      rdchk(4'h6, `MCRC_SEED_RST);
      rdchk(4'h4, 32'h00000001);
      rdchk(4'hF, 32'h00000000);
      // A data word while disabled is only stored and must leave the signature alone.
      acc(1'h1, 4'h3, 32'h00001234);
      rdchk(4'h3, 32'h00001234);
      rdchk(4'h6, s);
      acc(1'h1, 4'h0, 32'h00000001);
      words(3, 16'hA5C3);
      rdchk(4'h6, s);
      // New polynomial and seed, then a three-word block that matches.
      p = 32'h1EDC6F41;
      acc(1'h1, 4'h1, p);
      s = 32'h12345678;
      acc(1'h1, 4'h2, s);
      rdchk(4'h6, s);
      acc(1'h1, 4'h4, 32'h00000003);
      e = crc(crc(crc(s, 16'h0F00, p), 16'h0F01, p), 16'h0F02, p);
      acc(1'h1, 4'h5, e);
      rdchk(4'h5, e);
      acc(1'h1, 4'h0, 32'h00000007);
      words(3, 16'h0F00);
      rdchk(4'h8, e);
      // Busy and done are set after a good block, the error is not.
      acc(1'h0, 4'h7, 32'h0);
      `CHK({v[2:0], mismatch_irq}, 4'hA)
      // Same expectation on other words must flag an error and request.
      words(3, 16'h0F10);
      @(posedge clk);
      `CHK(mismatch_irq, 1'h1)
      acc(1'h0, 4'h7, 32'h0);
      `CHK(v[1], 1'h1)
      // Masking, unmasking, then clearing the sticky error.
      acc(1'h1, 4'h0, 32'h00000003);
      @(posedge clk);
      `CHK(mismatch_irq, 1'h0)
      acc(1'h1, 4'h0, 32'h00000007);
      @(posedge clk);
      `CHK(mismatch_irq, 1'h1)
      acc(1'h1, 4'h7, 32'h00000002);
      @(posedge clk);
      `CHK(mismatch_irq, 1'h0)
      // A seed in mid-block must restart the word count.
      acc(1'h1, 4'h0, 32'h00000001);
      words(2, 16'h0C00);
      s = 32'h13579BDF;
      acc(1'h1, 4'h2, s);
      words(3, 16'h0C10);
      rdchk(4'h8, s);
      // Advance steps the register as if a zero word arrived, and is not stored.
      acc(1'h1, 4'h0, 32'h00000009);
      s = crc(s, 16'h0000, p);
      rdchk(4'h6, s);
      rdchk(4'h0, 32'h00000001);
      rdchk(4'h6, s);
      // A reset in mid-run brings back the defaults and clears the flags.
      @(posedge clk);
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      rdchk(4'h1, `MCRC_POLY_RST);
      rdchk(4'h6, `MCRC_SEED_RST);
      rdchk(4'h7, 32'h00000000);
      close_out;
   end
endmodule
